// ===== esc_controller.sv
`timescale 1ns/1ps
// Overview of operation
// RL1: A 2048-byte store is addressed one byte at a time by a store pointer.
// RL2: Scratch-pad bytes at 0x0E10 to 0x0E3F hold the save sequence.
// RL3: Save and load start on demand through control registers 0x0E00 to 0x0E03.
// RL4: After power-up the two profile pins can trigger an automatic load.
// RL5: Scratch-pad reset contents form a sample save and restore sequence.
// RL6: Bytes 0x00 to 0x7F are data instructions moving value plus one bytes.
// RL7: Two bytes after a data instruction give the target, MSB first.
// RL8: Transfers start at the target address and count upward.
// RL9: Byte 0x80 during load issues an I/O update pulse.
// RL10: Byte 0xA0 during load starts system clock calibration.
// RL11: Byte 0xA1 during load issues one distribution sync pulse.
// RL12: Bytes 0xB0 to 0xCF are condition instructions; 0xB0 is null.
// RL13: Data and end act in both modes; pulse and condition bytes act only in load; pause acts only in save.
// RL14: Pause in save holds both pointers and is not written to store.
// RL15: A save after pause continues right after the previous sequence.
// RL16: End in save resets scratch and store pointers, then idles.
// RL17: End in load resets the store pointer, then idles.
// RL18: Save writes a one-byte checksum after each data block.
// RL19: Load compares each block checksum; a mismatch sets the fault flag.
// RL20: Load with all checksums matching sets the complete flag.
// RL21: Save starts from the self-clearing save bit only with write enable set.
// RL22: Self-clearing load bit starts a load; busy flag shows until done.
// RL23: After a data block the store pointer also steps over the checksum.
// RL24: A nonzero condition register overrides the pin-derived condition.
// RL25: Other save instructions, end included, are copied verbatim.
// RL26: The checksum is the modulo-256 sum of the block's data bytes.
module esc_controller (
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  input  wire esc_pkg::esc_regreq_t reg_req,
  output logic      [7:0]           reg_rdata,
  output esc_pkg::esc_mapreq_t      map_req,
  input  wire logic [7:0]           map_rdata,
  input  wire logic [1:0]           profile_select_pin_high,
  input  wire logic [1:0]           profile_select_pin_low,
  input  wire logic                 pin_control,
  output logic                      io_update_pulse,
  output logic                      calibrate_start,
  output logic                      dist_sync_pulse,
  output logic      [3:0]           active_condition,
  output logic      [4:0]           condition_tag,
  output logic      [3:0]           power_up_condition_code
);
  import esc_pkg::*;
  esc_state_t            state_r;
  esc_phase_t            phase_r;
  logic                  save_mode_r, ctrl_we_r, fault_r, done_r, boot_done_r, auto_go_r;
  logic [STORE_AW-1:0]   st_ptr_r;
  logic [SCR_AW-1:0]     sp_ptr_r;
  logic [15:0]           tgt_r;
  logic [6:0]            cnt_r;
  logic [7:0]            csum_r;
  logic [3:0]            cond_r;
  logic [7:0]            scr_r [SCR_DEPTH];
  logic [4:0]            pin_s1_r, pin_s2_r, pin_s3_r;
  logic [1:0]            boot_cnt_r;
  logic [7:0]            st_rdata, scr_q, cur_byte;
  logic                  is_data, is_cond, use_instr, save_pause, seq_end, st_we, st_rd;
  logic                  idle, save_go, load_go, scr_hit, csum_bad;
  logic [1:0]            lvl_hi, lvl_lo;
  logic [3:0]            pin_val, pin_id;
  esc_store_mem u_store (
    .clk   (clk),
    .rst_n (rst_n),
    .we    (st_we),
    .rd    (st_rd),
    .addr  (st_ptr_r), // [RL1]
    .wdata (cur_byte),
    .rdata (st_rdata)
  );
  assign idle    = (state_r == ST_IDLE);
  assign scr_hit = (reg_req.addr >= ADDR_SCR_LO) && (reg_req.addr <= ADDR_SCR_HI); // [RL2]
  assign save_go = idle && reg_req.wr && (reg_req.addr == ADDR_SAVE) && reg_req.wdata[SAVE_BIT]
                   && ctrl_we_r; // [RL3] [RL21]
  assign load_go = idle && !save_go && ((reg_req.wr && (reg_req.addr == ADDR_LOAD)
                   && reg_req.wdata[LOAD_BIT]) || auto_go_r); // [RL3] [RL22]
  // Reading past the scratch pad yields an end byte so a missing end cannot run away.
  assign scr_q = (sp_ptr_r <= SCR_LAST_IDX) ? scr_r[sp_ptr_r] : OP_END;
  always_comb begin
    if (!save_mode_r) begin
      cur_byte = st_rdata;
    end else if (phase_r == PH_DATA) begin
      cur_byte = map_rdata;
    end else if (phase_r == PH_CSUM) begin
      cur_byte = csum_r; // [RL18]
    end else begin
      cur_byte = scr_q;
    end
  end
  assign is_data    = (cur_byte <= OP_DATA_MAX); // [RL6]
  assign is_cond    = (cur_byte >= OP_COND_NULL) && (cur_byte <= OP_COND_LAST); // [RL12]
  assign use_instr  = (state_r == ST_USE) && (phase_r == PH_INSTR);
  assign save_pause = use_instr && save_mode_r && (cur_byte == OP_PAUSE); // [RL13] [RL14]
  assign seq_end    = use_instr && (cur_byte == OP_END);
  assign st_we      = save_mode_r && (state_r == ST_USE) && !save_pause; // [RL25] [RL14]
  assign st_rd      = !save_mode_r && (state_r == ST_REQ);
  assign csum_bad   = !save_mode_r && (state_r == ST_USE) && (phase_r == PH_CSUM)
                      && (st_rdata != csum_r); // [RL19]
  always_comb begin
    map_req.addr  = tgt_r;
    map_req.wdata = st_rdata;
    map_req.rd    = save_mode_r && (state_r == ST_REQ) && (phase_r == PH_DATA);
    map_req.wr    = !save_mode_r && (state_r == ST_USE) && (phase_r == PH_DATA);
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r     <= ST_IDLE;
      phase_r     <= PH_INSTR;
      save_mode_r <= 1'b0;
    end else begin
      case (state_r)
        ST_IDLE: begin
          phase_r <= PH_INSTR;
          if (save_go) begin
            state_r     <= ST_REQ;
            save_mode_r <= 1'b1;
          end else if (load_go) begin
            state_r     <= ST_REQ;
            save_mode_r <= 1'b0;
          end
        end
        ST_REQ: begin
          state_r <= ST_USE;
        end
        ST_USE: begin
          state_r <= (save_pause || seq_end) ? ST_IDLE : ST_REQ;
          case (phase_r)
            PH_INSTR:   phase_r <= (is_data && !seq_end) ? PH_ADDR_HI : PH_INSTR;
            PH_ADDR_HI: phase_r <= PH_ADDR_LO;
            PH_ADDR_LO: phase_r <= PH_DATA;
            PH_DATA:    phase_r <= (cnt_r == 7'h00) ? PH_CSUM : PH_DATA;
            default:    phase_r <= PH_INSTR;
          endcase
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end
  // Store pointer: kept across a pause so the next save appends.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ptr_r <= '0;
    end else if (load_go) begin
      st_ptr_r <= '0;
    end else if (seq_end) begin
      st_ptr_r <= '0; // [RL16] [RL17]
    end else if ((state_r == ST_USE) && !save_pause) begin
      st_ptr_r <= st_ptr_r + 1'b1; // [RL23]
    end
  end // [RL15]
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sp_ptr_r <= '0;
    end else if (save_go || seq_end) begin
      sp_ptr_r <= '0; // [RL16]
    end else if (save_mode_r && (state_r == ST_USE) && !save_pause
                 && ((phase_r == PH_INSTR) || (phase_r == PH_ADDR_HI)
                     || (phase_r == PH_ADDR_LO))) begin
      sp_ptr_r <= sp_ptr_r + 1'b1;
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tgt_r  <= 16'h0000;
      cnt_r  <= 7'h00;
      csum_r <= 8'h00;
    end else if (state_r == ST_USE) begin
      case (phase_r)
        PH_INSTR:   cnt_r <= cur_byte[6:0]; // [RL6]
        PH_ADDR_HI: tgt_r[15:8] <= cur_byte; // [RL7]
        PH_ADDR_LO: begin
          tgt_r[7:0] <= cur_byte;
          csum_r     <= 8'h00;
        end
        PH_DATA: begin
          tgt_r  <= tgt_r + 16'h0001; // [RL8]
          csum_r <= csum_r + cur_byte; // [RL26]
          cnt_r  <= cnt_r - 7'h01;
        end
        default:    csum_r <= csum_r;
      endcase
    end
  end
  // Only reset or a load clears the flags, and a load cannot start while one runs.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fault_r <= 1'b0;
      done_r  <= 1'b0;
    end else if (load_go) begin
      fault_r <= 1'b0;
      done_r  <= 1'b0;
    end else begin
      if (csum_bad) begin
        fault_r <= 1'b1; // [RL19]
      end
      if (seq_end && !save_mode_r && !fault_r) begin
        done_r <= 1'b1; // [RL20]
      end
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      io_update_pulse <= 1'b0;
      calibrate_start <= 1'b0;
      dist_sync_pulse <= 1'b0;
      condition_tag   <= 5'h00;
    end else begin
      io_update_pulse <= use_instr && !save_mode_r && (cur_byte == OP_IO_UPDATE); // [RL9]
      calibrate_start <= use_instr && !save_mode_r && (cur_byte == OP_CALIBRATE); // [RL10]
      dist_sync_pulse <= use_instr && !save_mode_r && (cur_byte == OP_DIST_SYNC); // [RL11]
      if (use_instr && !save_mode_r && is_cond) begin
        condition_tag <= cur_byte[4:0] - OP_COND_NULL[4:0]; // [RL12]
      end
    end
  end
  assign active_condition = (cond_r != 4'h0) ? cond_r : power_up_condition_code; // [RL24]
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_we_r <= 1'b0;
      cond_r    <= 4'h0;
    end else if (reg_req.wr) begin
      if (reg_req.addr == ADDR_CTRL_WE) begin
        ctrl_we_r <= reg_req.wdata[WE_BIT];
      end
      if (reg_req.addr == ADDR_COND) begin
        cond_r <= reg_req.wdata[3:0];
      end
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < SCR_DEPTH; i++) begin
        scr_r[i] <= esc_scr_init(i); // [RL5]
      end
    end else if (reg_req.wr && scr_hit) begin
      scr_r[reg_req.addr[5:0] - SCR_BASE_LOW] <= reg_req.wdata; // [RL2]
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_req.rd) begin
      if (reg_req.addr == ADDR_CTRL_WE) begin
        reg_rdata <= {7'h00, ctrl_we_r};
      end else if (reg_req.addr == ADDR_COND) begin
        reg_rdata <= {4'h0, cond_r};
      end else if (reg_req.addr == ADDR_STATUS) begin
        reg_rdata <= {4'h0, done_r, fault_r, !idle && !save_mode_r, !idle && save_mode_r};
      end else if (scr_hit) begin
        reg_rdata <= scr_r[reg_req.addr[5:0] - SCR_BASE_LOW];
      end else begin
        reg_rdata <= 8'h00;
      end
    end
  end
  // Pin levels: a level counts once the second and third stages agree.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1_r <= 5'h00;
      pin_s2_r <= 5'h00;
      pin_s3_r <= 5'h00;
    end else begin
      pin_s1_r <= {pin_control, profile_select_pin_high, profile_select_pin_low};
      pin_s2_r <= pin_s1_r;
      pin_s3_r <= pin_s2_r;
    end
  end
  // A code 2'h3 from the pad means no clear level, so treat it as open.
  assign lvl_hi  = (pin_s3_r[3:2] > PIN_HIGH) ? PIN_OPEN : pin_s3_r[3:2];
  assign lvl_lo  = (pin_s3_r[1:0] > PIN_HIGH) ? PIN_OPEN : pin_s3_r[1:0];
  assign pin_val = 4'(lvl_hi * PIN_BASE) + {2'b00, lvl_lo};
  assign pin_id  = (pin_val < PIN_ID_NONE) ? (pin_val + 4'h1)
                 : ((pin_val == PIN_ID_NONE) ? 4'h0 : pin_val);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      boot_cnt_r              <= 2'h0;
      boot_done_r             <= 1'b0;
      auto_go_r               <= 1'b0;
      power_up_condition_code <= 4'h0;
    end else begin
      if (load_go) begin
        auto_go_r <= 1'b0;
      end
      if (boot_cnt_r != BOOT_WAIT) begin
        boot_cnt_r <= boot_cnt_r + 2'h1;
      end else if (!boot_done_r && (pin_s2_r == pin_s3_r)) begin
        boot_done_r             <= 1'b1;
        power_up_condition_code <= pin_id; // [RL4]
        auto_go_r               <= (pin_id != 4'h0) && !pin_s3_r[4]; // [RL4]
      end
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_addr_bytes;
    ##2 (state_r == ST_USE) && (phase_r == PH_ADDR_HI)
    ##2 (state_r == ST_USE) && (phase_r == PH_ADDR_LO);
  endsequence
  sequence s_pulse_once(sig);
    sig ##1 !sig;
  endsequence
  a_save_start: assert property (save_go |=> (state_r == ST_REQ) && save_mode_r) // [RL21]
    else $error("save did not start");
  a_save_blocked: assert property (idle && reg_req.wr && (reg_req.addr == ADDR_SAVE)
    && !ctrl_we_r && !load_go |=> idle) // [RL21]
    else $error("save started without write enable");
  a_load_start: assert property (load_go |=> !save_mode_r && !idle && (st_ptr_r == '0)) // [RL22]
    else $error("load did not start at store start");
  a_pause_hold: assert property (save_pause |-> !st_we ##1 idle
    && (st_ptr_r == $past(st_ptr_r))) // [RL14]
    else $error("pause moved the store pointer or wrote it");
  a_end_reset: assert property (seq_end |=> idle && (st_ptr_r == '0) && (sp_ptr_r == '0)) // [RL16]
    else $error("end did not reset pointers");
  a_data_count: assert property (use_instr && is_data && !seq_end
    |=> {1'b0, cnt_r} == $past(cur_byte)) // [RL6]
    else $error("wrong transfer count");
  a_addr_order: assert property (use_instr && is_data && !seq_end |-> s_addr_bytes) // [RL7]
    else $error("address bytes not fetched in order");
  a_addr_msb: assert property ((state_r == ST_USE) && (phase_r == PH_ADDR_HI)
    |=> tgt_r[15:8] == $past(cur_byte)) // [RL7]
    else $error("address high byte misplaced");
  a_addr_up: assert property ((state_r == ST_USE) && (phase_r == PH_DATA)
    |=> tgt_r == $past(tgt_r) + 16'h0001) // [RL8]
    else $error("target address did not count up");
  a_fault_flag: assert property (csum_bad |=> fault_r ##1 fault_r) // [RL19]
    else $error("checksum mismatch not flagged");
  a_io_pulse: assert property (use_instr && !save_mode_r && (cur_byte == OP_IO_UPDATE)
    |=> s_pulse_once(io_update_pulse)) // [RL9]
    else $error("I/O update pulse wrong");
  a_sync_pulse: assert property (use_instr && !save_mode_r && (cur_byte == OP_DIST_SYNC)
    |=> s_pulse_once(dist_sync_pulse)) // [RL11]
    else $error("sync pulse wrong");

endmodule

// ===== esc_pkg.sv
package esc_pkg;

  localparam int          STORE_DEPTH   = 2048;
  localparam int          STORE_AW      = 11;
  localparam int          SCR_DEPTH     = 48;
  localparam int          SCR_AW        = 6;
  localparam logic [5:0]  SCR_LAST_IDX  = 6'h2f;
  localparam logic [5:0]  SCR_BASE_LOW  = 6'h10;

  localparam logic [15:0] ADDR_CTRL_WE  = 16'h0e00;
  localparam logic [15:0] ADDR_COND     = 16'h0e01;
  localparam logic [15:0] ADDR_SAVE     = 16'h0e02;
  localparam logic [15:0] ADDR_LOAD     = 16'h0e03;
  localparam logic [15:0] ADDR_STATUS   = 16'h0d00;
  localparam logic [15:0] ADDR_SCR_LO   = 16'h0e10;
  localparam logic [15:0] ADDR_SCR_HI   = 16'h0e3f;

  localparam int          WE_BIT        = 0;
  localparam int          SAVE_BIT      = 0;
  localparam int          LOAD_BIT      = 1;
  localparam int          STAT_SAVE     = 0;
  localparam int          STAT_LOAD     = 1;
  localparam int          STAT_FAULT    = 2;
  localparam int          STAT_DONE     = 3;

  localparam logic [7:0]  OP_DATA_MAX   = 8'h7f;
  localparam logic [7:0]  OP_IO_UPDATE  = 8'h80;
  localparam logic [7:0]  OP_CALIBRATE  = 8'ha0;
  localparam logic [7:0]  OP_DIST_SYNC  = 8'ha1;
  localparam logic [7:0]  OP_COND_NULL  = 8'hb0;
  localparam logic [7:0]  OP_COND_LAST  = 8'hcf;
  localparam logic [7:0]  OP_PAUSE      = 8'hfe;
  localparam logic [7:0]  OP_END        = 8'hff;

  // Three-level pin codes from the pad comparators.
  localparam logic [1:0]  PIN_LOW       = 2'h0;
  localparam logic [1:0]  PIN_OPEN      = 2'h1;
  localparam logic [1:0]  PIN_HIGH      = 2'h2;
  localparam logic [3:0]  PIN_BASE      = 4'h3;
  localparam logic [3:0]  PIN_ID_NONE   = 4'h4;
  localparam logic [1:0]  BOOT_WAIT     = 2'h3;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_REQ  = 3'b010,
    ST_USE  = 3'b100
  } esc_state_t;

  typedef enum logic [4:0] {
    PH_INSTR   = 5'b00001,
    PH_ADDR_HI = 5'b00010,
    PH_ADDR_LO = 5'b00100,
    PH_DATA    = 5'b01000,
    PH_CSUM    = 5'b10000
  } esc_phase_t;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } esc_regreq_t;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } esc_mapreq_t;

  // Sample sequence: save four bytes from 0x0100, I/O update, end.
  function automatic logic [7:0] esc_scr_init(input int idx);
    case (idx)
      0:       esc_scr_init = 8'h03;
      1:       esc_scr_init = 8'h01;
      2:       esc_scr_init = 8'h00;
      3:       esc_scr_init = OP_IO_UPDATE;
      default: esc_scr_init = OP_END;
    endcase
  endfunction

endpackage

// ===== esc_store_mem.sv
`timescale 1ns/1ps
module esc_store_mem (
  input  wire logic                         clk,
  input  wire logic                         rst_n,
  input  wire logic                         we,
  input  wire logic                         rd,
  input  wire logic [esc_pkg::STORE_AW-1:0] addr,
  input  wire logic [7:0]                   wdata,
  output logic      [7:0]                   rdata
);
  import esc_pkg::*;

  // The array has no reset: it models the nonvolatile cells.
  logic [7:0] mem_r [STORE_DEPTH];

  always_ff @(posedge clk) begin
    if (we) begin
      mem_r[addr] <= wdata;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= 8'h00;
    end else if (rd) begin
      rdata <= mem_r[addr];
    end
  end

endmodule

// ===== esc_map_model.sv
`timescale 1ns/1ps
module esc_map_model (
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  input  wire esc_pkg::esc_mapreq_t map_req,
  output logic      [7:0]           map_rdata
);
  import esc_pkg::*;
  logic [7:0] regs [0:511];
  logic [7:0] last_r;

  initial begin
    for (int i = 0; i < 512; i++) begin
      regs[i] = 8'(i * 7 + 8'h31);
    end
  end

  always @(posedge clk) begin
    if (map_req.wr === 1'b1) begin
      regs[map_req.addr[8:0]] <= map_req.wdata;
    end
  end

  // Read data is good for one cycle only; afterwards the inverse of it shows,
  // so a controller that samples late cannot match by luck.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      map_rdata <= 8'h00;
      last_r    <= 8'h00;
    end else if (map_req.rd === 1'b1) begin
      map_rdata <= regs[map_req.addr[8:0]];
      last_r    <= regs[map_req.addr[8:0]];
    end else begin
      map_rdata <= ~last_r;
    end
  end
endmodule

// ===== eeprom_sequence_controller_bench.sv
`timescale 1ns/1ps
module eeprom_sequence_controller_bench;
  import esc_pkg::*;
  logic        clk;
  logic        rst_n;
  esc_regreq_t reg_req;
  logic [7:0]  reg_rdata;
  esc_mapreq_t map_req;
  logic [7:0]  map_rdata;
  logic        io_update_pulse;
  logic        calibrate_start;
  logic        dist_sync_pulse;
  logic [3:0]  active_condition;
  logic [4:0]  condition_tag;
  logic [3:0]  power_up_condition_code;
  logic [1:0]  pin_hi;
  logic [1:0]  pin_lo;
  logic        pin_ctl;
  int          fail_count;
  int          checks_done;
  int          n_io;
  int          n_cal;
  int          n_sync;

  esc_controller dut_u (
    .clk(clk), .rst_n(rst_n), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .map_req(map_req), .map_rdata(map_rdata),
    .profile_select_pin_high(pin_hi), .profile_select_pin_low(pin_lo),
    .pin_control(pin_ctl), .io_update_pulse(io_update_pulse),
    .calibrate_start(calibrate_start), .dist_sync_pulse(dist_sync_pulse),
    .active_condition(active_condition), .condition_tag(condition_tag),
    .power_up_condition_code(power_up_condition_code)
  );

  esc_map_model map_u (.clk(clk), .rst_n(rst_n), .map_req(map_req), .map_rdata(map_rdata));

  initial clk = 1'b0;
  always #25 clk = ~clk;

  always @(posedge clk) begin
    if (io_update_pulse === 1'b1) n_io++;
    if (calibrate_start === 1'b1) n_cal++;
    if (dist_sync_pulse === 1'b1) n_sync++;
  end

  function automatic logic [7:0] orig(input int i);
    orig = 8'(i * 7 + 8'h31);
  endfunction

  task automatic tally_and_finish();
    $display("Checks made %0d, mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic chk_cnt(input int got, input int exp, input string what);
    checks_done++;
    if (got != exp) begin
      fail_count++;
      $display("ERROR at %0t: %s count %0d expected %0d", $time, what, got, exp);
    end
  endtask

  task automatic reg_wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    #2;
    reg_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk);
    #2;
    reg_req.wr = 1'b0;
  endtask

  task automatic reg_rd(input logic [15:0] a, output logic [7:0] d);
    @(posedge clk);
    #2;
    reg_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk);
    #2;
    reg_req.rd = 1'b0;
    d = reg_rdata;
  endtask

  task automatic rd_chk(input logic [15:0] a, input logic [7:0] exp, input string what);
    logic [7:0] d;
    reg_rd(a, d);
    chk8(d, exp, what);
  endtask

  task automatic wait_clear(input int b);
    logic [7:0] s;
    for (int i = 0; i < 2000; i++) begin
      reg_rd(ADDR_STATUS, s);
      if (s[b] === 1'b0) return;
    end
    fail_count++;
    $display("ERROR at %0t: status bit %0d never cleared", $time, b);
    tally_and_finish();
  endtask

  task automatic save_seq(input logic [7:0] q[$]);
    foreach (q[i]) reg_wr(ADDR_SCR_LO + 16'(i), q[i]);
    reg_wr(ADDR_SAVE, 8'h01);
    wait_clear(STAT_SAVE);
  endtask

  task automatic run_load();
    reg_wr(ADDR_LOAD, 8'h02);
    wait_clear(STAT_LOAD);
  endtask

  task automatic t_reset();
    logic [7:0] smp[5] = '{8'h03, 8'h01, 8'h00, 8'h80, 8'hff};
    foreach (smp[i]) rd_chk(ADDR_SCR_LO + 16'(i), smp[i], "scratch reset");
    rd_chk(ADDR_STATUS, 8'h00, "status reset");
    rd_chk(16'h0000, 8'h00, "unmapped read");
    chk8({4'h0, power_up_condition_code}, 8'h08, "pin code");
  endtask

  task automatic t_refuse();
    reg_wr(ADDR_SAVE, 8'h01);
    rd_chk(ADDR_STATUS, 8'h00, "save without enable");
    rd_chk(ADDR_SAVE, 8'h00, "save bit clears");
  endtask

  // Two saves joined by a pause, then one load must replay both blocks.
  task automatic t_pause_load();
    reg_wr(ADDR_CTRL_WE, 8'h01);
    save_seq('{8'h00, 8'h01, 8'h10, OP_PAUSE});
    save_seq('{8'h01, 8'h01, 8'h02, 8'h80, 8'ha0, 8'ha1, 8'hb3, OP_END});
    chk_cnt(n_io + n_cal + n_sync, 0, "pulses in save");
    map_u.regs[9'h110] = 8'h00;
    map_u.regs[9'h102] = 8'h00;
    map_u.regs[9'h103] = 8'h00;
    map_u.regs[9'h104] = 8'hee;
    run_load();
    chk8(map_u.regs[9'h110], orig(16'h110), "paused block");
    chk8(map_u.regs[9'h102], orig(16'h102), "block byte 0");
    chk8(map_u.regs[9'h103], orig(16'h103), "block byte 1");
    chk8(map_u.regs[9'h104], 8'hee, "past block end");
    chk_cnt(n_io, 1, "io update");
    chk_cnt(n_cal, 1, "calibrate");
    chk_cnt(n_sync, 1, "dist sync");
    chk8({3'h0, condition_tag}, 8'h03, "condition tag");
    rd_chk(ADDR_STATUS, 8'h08, "load status");
  endtask

  // After an end the next save must start the store afresh.
  task automatic t_end_reset();
    save_seq('{8'hb1, 8'hb2, 8'hb3, 8'hb4, 8'hb5, OP_END});
    map_u.regs[9'h102] = 8'h00;
    run_load();
    chk8({3'h0, condition_tag}, 8'h05, "tag after restart");
    chk8(map_u.regs[9'h102], 8'h00, "old block gone");
    chk_cnt(n_sync, 1, "no replay");
  endtask

  task automatic t_cond();
    chk8({4'h0, active_condition}, 8'h08, "pin condition");
    reg_wr(ADDR_COND, 8'h05);
    chk8({4'h0, active_condition}, 8'h05, "register condition");
    reg_wr(ADDR_COND, 8'h00);
    chk8({4'h0, active_condition}, 8'h08, "back to pins");
  endtask

  // A reset cuts a save before its checksum lands, so the automatic load that
  // the new pin levels ask for must meet the stale byte left there earlier.
  task automatic t_auto_fault();
    logic [7:0] blk[4] = '{8'h00, 8'h01, 8'h20, OP_END};
    foreach (blk[i]) reg_wr(ADDR_SCR_LO + 16'(i), blk[i]);
    reg_wr(ADDR_SAVE, 8'h01);
    repeat (9) @(posedge clk);
    #2;
    rst_n   = 1'b0;
    pin_hi  = PIN_LOW;
    pin_lo  = PIN_OPEN;
    pin_ctl = 1'b0;
    map_u.regs[9'h120] = 8'h00;
    repeat (3) @(posedge clk);
    #2;
    rst_n = 1'b1;
    repeat (8) @(posedge clk);
    rd_chk(ADDR_STATUS, 8'h02, "auto load busy");
    wait_clear(STAT_LOAD);
    chk8({4'h0, power_up_condition_code}, 8'h02, "pin code low open");
    chk8({4'h0, active_condition}, 8'h02, "pin condition after reset");
    chk8(map_u.regs[9'h120], orig(16'h120), "auto load block");
    rd_chk(ADDR_STATUS, 8'h04, "stale checksum");
  endtask

  initial begin
    fail_count  = 0;
    checks_done = 0;
    n_io        = 0;
    n_cal       = 0;
    n_sync      = 0;
    reg_req     = '0;
    pin_hi      = PIN_HIGH;
    pin_lo      = PIN_HIGH;
    pin_ctl     = 1'b1;
    rst_n       = 1'b0;
    repeat (3) @(posedge clk);
    #2;
    rst_n = 1'b1;
    repeat (8) @(posedge clk);
    t_reset();
    t_refuse();
    t_pause_load();
    t_end_reset();
    t_cond();
    t_auto_fault();
    tally_and_finish();
  end
endmodule
